/* File: tb.sv */
`timescale 1ns/10ps
`include "udt_regs.svh"
module tb;
  import udt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic ecp;
  logic dirp;
  logic dir_up = 1'b1;
  logic pulse_req = 1'b0;
  logic ce = 1'b1;
  logic clko;
  logic [31:0] rd;
  logic err;
  logic en_v;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int t = 0;
  always #5 pclk = ~pclk;
  udt_timer u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_pin(ecp), .direction_pin(dirp), .irq(irq),
    .clock_out(clko));
  udt_pin_model u_pins (.pclk(pclk), .presetn(presetn), .dir_up(dir_up),
    .pulse_req(pulse_req), .external_count_pin(ecp), .direction_pin(dirp));
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [15:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= 32'(d);
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask
  task automatic step(input logic [7:0] c, input logic m, input logic d,
      input logic [15:0] c0, input logic [15:0] r, input logic [15:0] e,
      input logic s, input logic x);
    t++;
    dir_up <= d;
    apb(1'b1, `UDT_OFS_RLD_LO, 16'(r[7:0]));
    apb(1'b1, `UDT_OFS_RLD_HI, 16'(r[15:8]));
    apb(1'b1, `UDT_OFS_CNT_LO, 16'(c0[7:0]));
    apb(1'b1, `UDT_OFS_CNT_HI, 16'(c0[15:8]));
    apb(1'b1, `UDT_OFS_MODE, 16'(m));
    apb(1'b1, `UDT_OFS_CTRL, 16'(c));
    pulse_req <= 1'b1;
    @(posedge pclk);
    pulse_req <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(32'(irq), 32'(s & en_v));
    rdc(`UDT_OFS_CTRL, 32'({x, 2'h0, c[4:0]}));
    apb(1'b1, `UDT_OFS_CTRL, 16'(c & 8'hfe));
    rdc(`UDT_OFS_CNT_LO, 32'(e[7:0]));
    rdc(`UDT_OFS_CNT_HI, 32'(e[15:8]));
    rdc(`UDT_OFS_STATUS, 32'(s));
    apb(1'b1, `UDT_OFS_CLEAR, 16'h0001);
    rdc(`UDT_OFS_STATUS, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    $display("test %0d done", t);
  endtask
  initial begin
    en_v = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rdc(8'(i * 4), 32'h0000_0000);
      chk(32'(err), 32'h0000_0000);
    end
    rdc(8'h40, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, `UDT_OFS_ENABLE, 16'h0001);
    step(8'h03, 1'b0, 1'b1, 16'hffff, 16'h1234, 16'h1234, 1, 0);
    step(8'h03, 1'b0, 1'b1, 16'h00ff, 16'h0000, 16'h0100, 0, 0);
    step(8'h03, 1'b0, 1'b0, 16'h0010, 16'h0000, 16'h0011, 0, 0);
    step(8'h03, 1'b1, 1'b0, 16'h1234, 16'h1234, 16'hffff, 1, 1);
    step(8'h03, 1'b1, 1'b0, 16'h1240, 16'h1234, 16'h123f, 0, 0);
    step(8'h03, 1'b1, 1'b1, 16'hffff, 16'h0055, 16'h0055, 1, 1);
    step(8'h02, 1'b0, 1'b1, 16'h0020, 16'h0000, 16'h0020, 0, 0);
    step(8'h07, 1'b0, 1'b1, 16'hffff, 16'h1234, 16'h0000, 1, 0);
    step(8'h0b, 1'b0, 1'b1, 16'hffff, 16'h1234, 16'h1234, 0, 0);
    en_v = 1'b0;
    apb(1'b1, `UDT_OFS_ENABLE, 16'h0000);
    step(8'h03, 1'b0, 1'b1, 16'hffff, 16'h0001, 16'h0001, 1, 0);
    // Clock output follows the up overflow
    t++;
    apb(1'b1, `UDT_OFS_MODE, 16'h0002);
    apb(1'b1, `UDT_OFS_CNT_LO, 16'h00ff);
    apb(1'b1, `UDT_OFS_CNT_HI, 16'h00ff);
    apb(1'b1, `UDT_OFS_CTRL, 16'h0003);
    pulse_req <= 1'b1;
    @(posedge pclk);
    pulse_req <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(32'(clko), 32'h0000_0001);
    rdc(`UDT_OFS_CNT_LO, 32'h0000_0001);
    $display("test %0d done", t);
    // Prescaler phase is free running, so allow one step either way
    t++;
    apb(1'b1, `UDT_OFS_CNT_LO, 16'h0000);
    apb(1'b1, `UDT_OFS_CNT_HI, 16'h0000);
    apb(1'b1, `UDT_OFS_CTRL, 16'h0001);
    repeat (120) @(posedge pclk);
    // Frozen cycles must not add to the count
    ce <= 1'b0;
    repeat (60) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b1, `UDT_OFS_CTRL, 16'h0000);
    apb(1'b0, `UDT_OFS_CNT_LO, 16'h0000);
    num_checks++;
    if ($isunknown(rd) || rd < 32'h0000_0009 || rd > 32'h0000_000b) begin
      failures++;
      $display("unexpected at %0t: timer count %h", $time, rd);
    end
    $display("test %0d done", t);
    complete_run();
  end
endmodule // tb

/* File: udt_pin_model.sv */
`timescale 1ns/10ps
module udt_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dir_up,
  input wire logic pulse_req,
  output logic external_count_pin,
  output logic direction_pin
);
  logic [2:0] low_cnt;
  // Pin idles high; held low long enough to pass the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 3'h0;
      external_count_pin <= 1'b1;
      direction_pin <= 1'b1;
    end else begin
      direction_pin <= dir_up;
      if (pulse_req) begin
        low_cnt <= 3'h5;
        external_count_pin <= 1'b0;
      end else if (low_cnt != 3'h0) begin
        low_cnt <= low_cnt - 3'h1;
        external_count_pin <= (low_cnt == 3'h1);
      end
    end
  end
endmodule // udt_pin_model

/* File: udt_pkg.sv */
package udt_pkg;

`include "udt_regs.svh"

typedef enum logic [1:0] {
  UDT_MODE_CAPTURE,
  UDT_MODE_RELOAD,
  UDT_MODE_BAUD
} udt_mode_e;

typedef struct packed {
  logic [7:0] ctrl;
  logic [1:0] tmode;
  logic [15:0] cnt;
  logic [15:0] rld;
  logic ovf;
  logic ovf_en;
  logic [`UDT_PRE_W-1:0] pre;
  logic cnt_pin_prev;
  logic clk_out;
  logic irq;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
} udt_state_s;

typedef struct packed {
  logic [1:0] s1;
  logic [1:0] s2;
} udt_sync_s;

endpackage

/* File: udt_regs.svh */
`ifndef UDT_REGS_SVH
`define UDT_REGS_SVH

// Register byte offsets on the APB
`define UDT_ADDR_W 8
`define UDT_OFS_CTRL 8'h00
`define UDT_OFS_MODE 8'h04
`define UDT_OFS_CNT_LO 8'h08
`define UDT_OFS_CNT_HI 8'h0c
`define UDT_OFS_RLD_LO 8'h10
`define UDT_OFS_RLD_HI 8'h14
`define UDT_OFS_STATUS 8'h18
`define UDT_OFS_CLEAR 8'h1c
`define UDT_OFS_ENABLE 8'h20

// Control register fields
`define UDT_CTRL_RUN 0
`define UDT_CTRL_CT 1
`define UDT_CTRL_CPRL 2
`define UDT_CTRL_RCLK 3
`define UDT_CTRL_TRANSMIT_CLOCK_SELECT 4
`define UDT_CTRL_EXF 7

// Mode register fields
`define UDT_MODE_DOWN_COUNT_ENABLE 0
`define UDT_MODE_CLKOE 1

// Status, clear and enable fields
`define UDT_ST_OVF 0

// Reset values
`define UDT_RST_CTRL 8'h00
`define UDT_RST_MODE 2'h0
`define UDT_RST_CNT 16'h0000
`define UDT_RST_RLD 16'h0000
`define UDT_RST_PRE 4'h0
`define UDT_RST_DATA 32'h0000_0000

// Count limits and the timer-function prescaler
`define UDT_CNT_TOP 16'hffff
`define UDT_TIMER_DIV 12
`define UDT_PRE_W 4

`endif

/* File: udt_sync.sv */
`timescale 1ns/10ps
module udt_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [1:0] pin_async,
  output logic [1:0] pin_sync
);
  import udt_pkg::*;

  udt_sync_s q;
  udt_sync_s d;

  // First stage feeds only the second stage
  always_comb begin
    d = q;
    if (ce) begin
      d.s1 = pin_async;
      d.s2 = q.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_sync = q.s2;
endmodule // udt_sync

/* File: udt_timer.sv */
// Function
// - Sixteen-bit count kept as low and high bytes, low carrying into high.
// - Select bit picks clock divided by twelve or external pin edges.
// - Count advances only while run bit is set, otherwise holds.
// - Capture, auto-reload and baud modes chosen from three select bits.
// - Down-count enable clear: auto-reload counts up only, direction ignored.
// - Down-count enable set: direction pin picks up or down counting in auto-reload mode.
// - Counting up, overflow past FFFFh sets overflow flag and interrupt, except in baud mode.
// - Up overflow loads the reload value into the count bytes, or zero in capture mode.
// - Counting down, underflow when count equals reload value.
// - Down underflow sets overflow flag and loads FFFFh.
// - External flag toggles on each up/down-mode wrap, never requests an interrupt.
// - Clock output toggles on each up overflow while its own enable is set, in any mode, baud or not.
`timescale 1ns/10ps
`include "udt_regs.svh"
module udt_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [`UDT_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic direction_pin,
  output logic irq,
  output logic clock_out
);
  import udt_pkg::*;

  udt_state_s q;
  udt_state_s d;
  logic [1:0] pins_sync;
  logic cnt_pin_s;
  logic dir_s;
  udt_mode_e mode;
  logic down_count_enable;
  logic updown;
  logic count_up;
  logic pre_wrap;
  logic cnt_edge;
  logic advance;
  logic at_top;
  logic at_floor;
  logic ovf_ev;
  logic unf_ev;
  logic wrap_ev;
  logic setup;
  logic acc;
  logic wr;
  logic wr_cnt;
  logic clr_ovf;
  logic mapped;

  localparam logic [`UDT_PRE_W-1:0] PRE_LAST =
    `UDT_PRE_W'(`UDT_TIMER_DIV - 1);

  // Both pins cross from outside before any logic looks at them
  udt_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_async({direction_pin, external_count_pin}),
    .pin_sync(pins_sync)
  );
  assign cnt_pin_s = pins_sync[0];
  assign dir_s = pins_sync[1];

  // Baud selects win over capture, as only one mode can own the reload
  always_comb begin
    if (q.ctrl[`UDT_CTRL_RCLK] || q.ctrl[`UDT_CTRL_TRANSMIT_CLOCK_SELECT]) begin
      mode = UDT_MODE_BAUD;
    end else if (q.ctrl[`UDT_CTRL_CPRL]) begin
      mode = UDT_MODE_CAPTURE;
    end else begin
      mode = UDT_MODE_RELOAD;
    end
  end

  assign down_count_enable = q.tmode[`UDT_MODE_DOWN_COUNT_ENABLE];
  assign updown = (mode == UDT_MODE_RELOAD) && down_count_enable;
  // Legacy mode ignores the direction pin
  assign count_up = !updown || dir_s;

  // Counter function counts falling edges of the synchronised pin
  assign pre_wrap = (q.pre == PRE_LAST);
  assign cnt_edge = q.cnt_pin_prev && !cnt_pin_s;
  assign advance = ce && q.ctrl[`UDT_CTRL_RUN] &&
    (q.ctrl[`UDT_CTRL_CT] ? cnt_edge : pre_wrap);

  assign at_top = (q.cnt == `UDT_CNT_TOP);
  assign at_floor = (q.cnt == q.rld);
  assign ovf_ev = advance && count_up && at_top;
  assign unf_ev = advance && !count_up && at_floor;
  assign wrap_ev = ovf_ev || unf_ev;

  // Zero-wait APB: pready rises for the access cycle only
  assign setup = ce && psel && !penable;
  assign acc = ce && psel && penable && q.pready;
  assign wr = acc && pwrite;
  assign wr_cnt = wr && ((paddr == `UDT_OFS_CNT_LO) ||
    (paddr == `UDT_OFS_CNT_HI));
  assign clr_ovf = wr && (paddr == `UDT_OFS_CLEAR) &&
    pwdata[`UDT_ST_OVF];

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `UDT_OFS_CTRL, `UDT_OFS_MODE, `UDT_OFS_CNT_LO, `UDT_OFS_CNT_HI,
      `UDT_OFS_RLD_LO, `UDT_OFS_RLD_HI, `UDT_OFS_STATUS,
      `UDT_OFS_CLEAR, `UDT_OFS_ENABLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    if (ce) begin
      d.pre = pre_wrap ? `UDT_RST_PRE : q.pre + `UDT_PRE_W'(1);
      d.cnt_pin_prev = cnt_pin_s;

      // Count path, the 16-bit add carries low byte into high
      if (advance) begin
        if (count_up) begin
          if (!at_top) begin
            d.cnt = q.cnt + 16'h0001;
          end else if (mode == UDT_MODE_CAPTURE) begin
            d.cnt = `UDT_RST_CNT;
          end else begin
            d.cnt = q.rld;
          end
        end else begin
          if (at_floor) begin
            d.cnt = `UDT_CNT_TOP;
          end else begin
            d.cnt = q.cnt - 16'h0001;
          end
        end
      end

      // Register writes, taken at the access edge
      if (wr) begin
        unique case (paddr)
          `UDT_OFS_CTRL: d.ctrl = pwdata[7:0];
          `UDT_OFS_MODE: d.tmode = pwdata[1:0];
          `UDT_OFS_CNT_LO: d.cnt[7:0] = pwdata[7:0];
          `UDT_OFS_CNT_HI: d.cnt[15:8] = pwdata[7:0];
          `UDT_OFS_RLD_LO: d.rld[7:0] = pwdata[7:0];
          `UDT_OFS_RLD_HI: d.rld[15:8] = pwdata[7:0];
          `UDT_OFS_ENABLE: d.ovf_en = pwdata[`UDT_ST_OVF];
          default: d.ovf_en = q.ovf_en;
        endcase
      end

      // Extra count bit, flips on each up/down-mode wrap, applied after any software write; no interrupt
      if (wrap_ev && updown) begin
        d.ctrl[`UDT_CTRL_EXF] = !d.ctrl[`UDT_CTRL_EXF];
      end

      // Sticky flag, a wrap in the clear cycle wins over the clear
      d.ovf = (q.ovf && !clr_ovf) ||
        (ovf_ev && mode != UDT_MODE_BAUD) || unf_ev;

      // Clock output toggles on each up overflow while its enable is set, in any mode
      if (ovf_ev && q.tmode[`UDT_MODE_CLKOE]) begin
        d.clk_out = !q.clk_out;
      end

      d.irq = d.ovf && d.ovf_en;

      d.pready = setup;
      d.pslverr = setup && !mapped;
      d.prdata = `UDT_RST_DATA;
      if (setup && !pwrite) begin
        unique case (paddr)
          `UDT_OFS_CTRL: d.prdata[7:0] = q.ctrl;
          `UDT_OFS_MODE: d.prdata[1:0] = q.tmode;
          `UDT_OFS_CNT_LO: d.prdata[7:0] = q.cnt[7:0];
          `UDT_OFS_CNT_HI: d.prdata[7:0] = q.cnt[15:8];
          `UDT_OFS_RLD_LO: d.prdata[7:0] = q.rld[7:0];
          `UDT_OFS_RLD_HI: d.prdata[7:0] = q.rld[15:8];
          `UDT_OFS_STATUS: d.prdata[`UDT_ST_OVF] = q.ovf;
          `UDT_OFS_ENABLE: d.prdata[`UDT_ST_OVF] = q.ovf_en;
          default: d.prdata = `UDT_RST_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.ctrl <= `UDT_RST_CTRL;
      q.tmode <= `UDT_RST_MODE;
      q.cnt <= `UDT_RST_CNT;
      q.rld <= `UDT_RST_RLD;
      q.ovf <= 1'b0;
      q.ovf_en <= 1'b0;
      q.pre <= `UDT_RST_PRE;
      q.cnt_pin_prev <= 1'b0;
      q.clk_out <= 1'b0;
      q.irq <= 1'b0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata <= `UDT_RST_DATA;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign clock_out = q.clk_out;

  // Checks on counting behaviour
  chk_hold_when_stopped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!q.ctrl[`UDT_CTRL_RUN] && !wr_cnt) |=> $stable(q.cnt)
  ) else $error("count moved while stopped");

  chk_prescale_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && pre_wrap) |=> !pre_wrap [*8]
  ) else $error("prescaler wrapped too early");

  chk_legacy_count_up: assert property (
    @(posedge pclk) disable iff (!presetn)
    (advance && mode == UDT_MODE_RELOAD && !down_count_enable && !at_top && !wr_cnt)
    |=> q.cnt == $past(q.cnt) + 16'h0001
  ) else $error("legacy mode did not count up");

  chk_down_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    (advance && updown && !dir_s && !at_floor && !wr_cnt)
    |=> q.cnt == $past(q.cnt) - 16'h0001
  ) else $error("down count did not decrement");

  chk_up_overflow_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ovf_ev && mode == UDT_MODE_RELOAD && !wr_cnt)
    |=> q.cnt == $past(q.rld)
  ) else $error("overflow did not reload");

  chk_overflow_flag_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ovf_ev && mode == UDT_MODE_RELOAD && q.ovf_en && !wr)
    |=> q.ovf && q.irq
  ) else $error("overflow flag or interrupt missing");

  chk_underflow_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    (unf_ev && !wr_cnt) |=> q.cnt == `UDT_CNT_TOP && q.ovf
  ) else $error("underflow did not load top value");

  chk_underflow_compare: assert property (
    @(posedge pclk) disable iff (!presetn)
    (advance && !count_up && q.cnt != q.rld && !wr_cnt)
    |=> q.cnt != `UDT_CNT_TOP || $past(q.cnt) == 16'h0000
  ) else $error("underflow taken before reload value");

  chk_ext_flag_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wrap_ev && updown && !wr)
    |=> q.ctrl[`UDT_CTRL_EXF] != $past(q.ctrl[`UDT_CTRL_EXF])
  ) else $error("external flag did not toggle");

  chk_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.ovf && !clr_ovf) |=> q.ovf
  ) else $error("overflow flag cleared itself");

  chk_clock_out_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ovf_ev && q.tmode[`UDT_MODE_CLKOE]) |=> q.clk_out != $past(q.clk_out)
  ) else $error("clock output missed a wrap");

  chk_dir_synced: assert property (
    @(posedge pclk) disable iff (!presetn)
    (presetn && ce) [*3] |-> dir_s == $past(direction_pin, 2)
  ) else $error("direction not taken through two stages");

  // Checks on the register bus, clock enable, count gating, wraps and flags
  chk_ready_after_setup: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && setup) |=> pready
  ) else $error("ready missing after setup");

  chk_ready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !setup) |=> !pready
  ) else $error("ready held past the access cycle");

  chk_error_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && setup) |=> pslverr == !$past(mapped)
  ) else $error("error response does not match the address map");

  chk_read_data_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && !setup) |=> prdata == `UDT_RST_DATA
  ) else $error("read data not zero outside access");

  chk_ce_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(q)
  ) else $error("state moved with clock enable low");

  chk_counter_edge_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && q.ctrl[`UDT_CTRL_RUN] && q.ctrl[`UDT_CTRL_CT] && !cnt_edge &&
      !wr_cnt) |=> $stable(q.cnt)
  ) else $error("counter moved without a pin edge");

  chk_timer_prescale_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ce && q.ctrl[`UDT_CTRL_RUN] && !q.ctrl[`UDT_CTRL_CT] && !pre_wrap &&
      !wr_cnt) |=> $stable(q.cnt)
  ) else $error("timer moved between prescaler wraps");

  chk_capture_wrap_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ovf_ev && mode == UDT_MODE_CAPTURE && !wr_cnt)
    |=> q.cnt == `UDT_RST_CNT && q.ovf
  ) else $error("capture mode wrap not to zero");

  chk_baud_no_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ovf_ev && mode == UDT_MODE_BAUD && !q.ovf) |=> !q.ovf
  ) else $error("baud mode wrap set the overflow flag");

  chk_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (q.ovf && clr_ovf && !ovf_ev && !unf_ev) |=> !q.ovf
  ) else $error("overflow flag did not clear");

  chk_ext_flag_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!updown && !(wr && paddr == `UDT_OFS_CTRL))
    |=> $stable(q.ctrl[`UDT_CTRL_EXF])
  ) else $error("external flag moved outside up/down mode");

endmodule // udt_timer
